// ### tmc_pin_model.sv
// Pin-side model: external timer clock, capture pins and sub clock ticks
`timescale 1ns/1ps
module tmc_pin_model (
    input wire logic clk_in,
    output logic [3:0] ext_clk_out,
    output logic [3:0] capture_out,
    output logic sub_tick_out
);
    int sub_cnt = 0;
    initial begin
        ext_clk_out = 4'h0;
        capture_out = 4'h0;
        sub_tick_out = 1'b0;
    end
    // Sub clock: a one-cycle tick every 8 core cycles
    always @(posedge clk_in) begin
        sub_cnt <= (sub_cnt + 1) % 8;
        sub_tick_out <= (sub_cnt == 7);
    end
    // Each level holds at least 3 cycles so the two-flop synchroniser cannot miss it
    task automatic ext_pulses(input int idx, input int n);
        repeat (n) begin
            @(posedge clk_in);
            ext_clk_out[idx] <= 1'b1;
            repeat (3) @(posedge clk_in);
            ext_clk_out[idx] <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
    endtask
    task automatic set_cap(input int idx, input logic lvl);
        @(posedge clk_in);
        capture_out[idx] <= lvl;
    endtask
endmodule

// ### tmc_pkg.sv
// Package: constants, enums and state structs of the timer module common framework
package tmc_pkg;
    localparam int NUM_TMR = 4;
    localparam int NUM_INV = 2;
    localparam int AW = 6;
    localparam int DW = 16;
    // ----------------------------------------------------------------
    // Register map: timer t at t*8, globals above
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_CTRL0 = 3'h0;
    localparam logic [2:0] REG_CTRL1 = 3'h1;
    localparam logic [2:0] REG_CNT = 3'h2;
    localparam logic [2:0] REG_CCRA = 3'h3;
    localparam logic [2:0] REG_CCRP = 3'h4;
    localparam logic [AW-1:0] ADDR_INT_STAT = 6'h20;
    localparam logic [AW-1:0] ADDR_INT_MASK = 6'h21;
    localparam int C0_PAUSE = 7;
    localparam int C0_CLK_LSB = 4;
    localparam int C0_ON = 3;
    localparam int C0_CAPSRC = 0;
    localparam int C1_MODE_LSB = 6;
    localparam int C1_IO_LSB = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_CCLR = 0;
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;
    localparam logic [1:0] IO_SINGLE = 2'h3;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [5:0] DIV_RST = 6'h00;

    typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} tmc_mode_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } tmc_bus_t;

    typedef struct packed {
        logic pause;
        logic [2:0] clksel;
        logic on;
        logic capsrc;
        tmc_mode_t mode;
        logic [1:0] io;
        logic oc;
        logic pol;
        logic cclr;
        logic [15:0] cnt;
        logic [15:0] ccra;
        logic [7:0] ccrp;
        logic out;
        logic pulse_run;
    } tmc_tmr_t;

    typedef struct packed {
        logic [NUM_TMR-1:0] ext_s1;
        logic [NUM_TMR-1:0] ext_s2;
        logic [NUM_TMR-1:0] ext_s3;
        logic [NUM_TMR-1:0] cap_s1;
        logic [NUM_TMR-1:0] cap_s2;
        logic [NUM_TMR-1:0] cap_s3;
        logic [5:0] div;
        logic [2*NUM_TMR-1:0] status;
        logic [2*NUM_TMR-1:0] mask;
        logic [DW-1:0] rdata;
        logic [NUM_INV-1:0] inv;
        tmc_tmr_t [NUM_TMR-1:0] tmr;
    } tmc_state_t;
endpackage

// ### tmc_top.sv
// Four-channel timer block: standard timer at index 0, periodic timers at 1 to 3
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module tmc_top import tmc_pkg::*; (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire tmc_bus_t bus_in,
    input wire logic sub_tick_in,
    input wire logic [NUM_TMR-1:0] ext_clk_in,
    input wire logic [NUM_TMR-1:0] capture_in,
    output logic [DW-1:0] rdata_out,
    output logic [NUM_TMR-1:0] out_pin_out,
    output logic [NUM_INV-1:0] inv_pin_out,
    output logic irq_out
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // High clock is taken as the core clock; sub clock arrives as a one-cycle tick
    function automatic logic tick_sel(input logic [2:0] sel, input logic [5:0] div,
                                      input logic sub, input logic rise, input logic fall);
        case (sel)
            CK_SYS4: tick_sel = (div[1:0] == 2'h3);
            CK_SYS: tick_sel = 1'b1;
            CK_H16: tick_sel = (div[3:0] == 4'hF);
            CK_H64: tick_sel = (div == 6'h3F);
            CK_EXT_RISE: tick_sel = rise;
            CK_EXT_FALL: tick_sel = fall;
            default: tick_sel = sub;
        endcase
    endfunction

    // Comparator P sees the top byte; zero stands for a full 16-bit wrap
    function automatic logic p_hit(input logic [15:0] cnt, input logic [7:0] ccrp);
        if (ccrp == 8'h00) begin
            p_hit = (cnt == CNT_TOP);
        end else begin
            p_hit = (cnt == {ccrp, 8'h00});
        end
    endfunction

    tmc_state_t s_r;
    tmc_state_t s_nxt;
    logic [NUM_TMR-1:0] ext_rise;
    logic [NUM_TMR-1:0] ext_fall;
    logic [NUM_TMR-1:0] tick;
    logic [NUM_TMR-1:0] cap_evt;
    logic [NUM_TMR-1:0] match_a;
    logic [NUM_TMR-1:0] match_p;
    logic [NUM_TMR-1:0] start;
    logic tmr_hit;
    logic [2:0] rsel;
    logic [1:0] tsel;
    logic [2*NUM_TMR-1:0] clr_mask;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        tmc_tmr_t t;
        tmc_tmr_t nt;
        logic crise;
        logic cfall;
        logic active;
        t = '0;
        nt = '0;
        crise = 1'b0;
        cfall = 1'b0;
        active = 1'b0;
        s_nxt = s_r;
        // Two flops per pin, a third only for edge history
        s_nxt.ext_s1 = ext_clk_in;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_s3 = s_r.ext_s2;
        s_nxt.cap_s1 = capture_in;
        s_nxt.cap_s2 = s_r.cap_s1;
        s_nxt.cap_s3 = s_r.cap_s2;
        s_nxt.div = s_r.div + 6'h01;
        ext_rise = s_r.ext_s2 & ~s_r.ext_s3;
        ext_fall = ~s_r.ext_s2 & s_r.ext_s3;
        tmr_hit = (bus_in.addr[AW-1] == 1'b0);
        tsel = bus_in.addr[4:3];
        rsel = bus_in.addr[2:0];
        clr_mask = '0;
        if (bus_in.wr && bus_in.addr == ADDR_INT_STAT) begin
            clr_mask = bus_in.wdata[2*NUM_TMR-1:0];
        end
        if (bus_in.wr && bus_in.addr == ADDR_INT_MASK) begin
            s_nxt.mask = bus_in.wdata[2*NUM_TMR-1:0];
        end
        s_nxt.status = s_r.status & ~clr_mask;
        for (int i = 0; i < NUM_TMR; i++) begin
            t = s_r.tmr[i];
            nt = t;
            start[i] = 1'b0;
            // Register writes first, so hardware events below override them
            if (bus_in.wr && tmr_hit && tsel == 2'(i)) begin
                case (rsel)
                    REG_CTRL0: begin
                        nt.pause = bus_in.wdata[C0_PAUSE];
                        nt.clksel = bus_in.wdata[C0_CLK_LSB +: 3];
                        nt.on = bus_in.wdata[C0_ON];
                        nt.capsrc = bus_in.wdata[C0_CAPSRC] && (i != 0);
                        start[i] = bus_in.wdata[C0_ON] && !t.on;
                    end
                    REG_CTRL1: begin
                        nt.mode = tmc_mode_t'(bus_in.wdata[C1_MODE_LSB +: 2]);
                        nt.io = bus_in.wdata[C1_IO_LSB +: 2];
                        nt.oc = bus_in.wdata[C1_OC];
                        nt.pol = bus_in.wdata[C1_POL];
                        nt.cclr = bus_in.wdata[C1_CCLR];
                    end
                    REG_CCRA: nt.ccra = bus_in.wdata;
                    REG_CCRP: nt.ccrp = bus_in.wdata[7:0];
                    default: nt.cnt = t.cnt;
                endcase
            end
            // Turning on restarts the count and, in compare mode only, restores the initial output level
            if (start[i]) begin
                nt.cnt = '0;
                nt.pulse_run = 1'b0;
                if (nt.mode == MODE_CMP) begin
                    nt.out = nt.oc;
                end
            end
            // Periodic timers may take the clock pin as capture source
            crise = t.capsrc ? ext_rise[i] : (s_r.cap_s2[i] & ~s_r.cap_s3[i]);
            cfall = t.capsrc ? ext_fall[i] : (~s_r.cap_s2[i] & s_r.cap_s3[i]);
            tick[i] = tick_sel(t.clksel, s_r.div, sub_tick_in,
                               ext_rise[i], ext_fall[i]);
            active = t.on && !start[i] && tick[i] && !t.pause &&
                     !(t.mode == MODE_PWM && t.io == IO_SINGLE && !t.pulse_run);
            match_a[i] = active && (t.mode != MODE_CAP) && (t.cnt == t.ccra);
            match_p[i] = active && p_hit(t.cnt, t.ccrp);
            cap_evt[i] = t.on && (t.mode == MODE_CAP) &&
                         (((t.io == CAP_RISE || t.io == CAP_BOTH) && crise) ||
                          ((t.io == CAP_FALL || t.io == CAP_BOTH) && cfall));
            if (active) begin
                nt.cnt = (match_p[i] || (match_a[i] && t.cclr)) ? '0 : t.cnt + 16'h0001;
            end
            if (t.on && !start[i]) begin
                case (t.mode)
                    MODE_CMP: begin
                        if (match_a[i]) begin
                            case (t.io)
                                IO_LOW: nt.out = 1'b0;
                                IO_HIGH: nt.out = 1'b1;
                                IO_TOGGLE: nt.out = !t.out;
                                default: nt.out = t.out;
                            endcase
                        end
                    end
                    MODE_CAP: begin
                        if (cap_evt[i]) begin
                            nt.ccra = t.cnt;
                        end
                    end
                    MODE_PWM: begin
                        if (t.io == IO_SINGLE) begin
                            // Clock pin edge fires one pulse; comparator A ends it
                            if (ext_rise[i] && !t.pulse_run) begin
                                nt.pulse_run = 1'b1;
                                nt.cnt = '0;
                                nt.out = !t.pol;
                            end else if (match_a[i]) begin
                                nt.pulse_run = 1'b0;
                                nt.out = t.pol;
                            end
                        end else begin
                            nt.out = t.pol ^ (t.cnt < t.ccra);
                        end
                    end
                    default: nt.out = t.out;
                endcase
            end
            // Set wins over a clear in the same cycle
            s_nxt.status[2*i] = s_nxt.status[2*i] | match_a[i] | cap_evt[i];
            s_nxt.status[2*i+1] = s_nxt.status[2*i+1] | match_p[i];
            s_nxt.tmr[i] = nt;
        end
        // Complement pins only exist on the first two timers
        s_nxt.inv = ~{s_nxt.tmr[1].out, s_nxt.tmr[0].out};
        s_nxt.rdata = '0;
        if (bus_in.rd) begin
            if (bus_in.addr == ADDR_INT_STAT) begin
                s_nxt.rdata = DW'(s_r.status);
            end else if (bus_in.addr == ADDR_INT_MASK) begin
                s_nxt.rdata = DW'(s_r.mask);
            end else if (tmr_hit) begin
                t = s_r.tmr[tsel];
                case (rsel)
                    REG_CTRL0: begin
                        s_nxt.rdata[C0_PAUSE] = t.pause;
                        s_nxt.rdata[C0_CLK_LSB +: 3] = t.clksel;
                        s_nxt.rdata[C0_ON] = t.on;
                        s_nxt.rdata[C0_CAPSRC] = t.capsrc;
                    end
                    REG_CTRL1: begin
                        s_nxt.rdata[C1_MODE_LSB +: 2] = t.mode;
                        s_nxt.rdata[C1_IO_LSB +: 2] = t.io;
                        s_nxt.rdata[C1_OC] = t.oc;
                        s_nxt.rdata[C1_POL] = t.pol;
                        s_nxt.rdata[C1_CCLR] = t.cclr;
                    end
                    REG_CNT: s_nxt.rdata = t.cnt;
                    REG_CCRA: s_nxt.rdata = t.ccra;
                    REG_CCRP: s_nxt.rdata = DW'(t.ccrp);
                    default: s_nxt.rdata = '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
            s_r.div <= DIV_RST;
            s_r.inv <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        rdata_out = s_r.rdata;
        irq_out = |(s_r.status & s_r.mask);
        inv_pin_out = s_r.inv;
        for (int i = 0; i < NUM_TMR; i++) begin
            out_pin_out[i] = s_r.tmr[i].out;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_inv_complement: assert property (inv_pin_out == ~out_pin_out[NUM_INV-1:0])
        else $error("inverted pin is not the complement of its output");

    a_sys4_divide: assert property (s_r.tmr[3].on && !start[3] && !s_r.tmr[3].pause
        && s_r.tmr[3].mode == MODE_TMR && s_r.tmr[3].clksel == CK_SYS4
        && s_r.div[1:0] != 2'h3 |=> $stable(s_r.tmr[3].cnt))
        else $error("divide by four counted off phase");

    a_h16_divide: assert property (s_r.tmr[3].on && !start[3] && !s_r.tmr[3].pause
        && s_r.tmr[3].mode == MODE_TMR && s_r.tmr[3].clksel == CK_H16
        && s_r.div[3:0] != 4'hF |=> $stable(s_r.tmr[3].cnt))
        else $error("divide by sixteen counted off phase");

    a_ext_rise_count: assert property ($rose(ext_clk_in[1]) ##1 ext_clk_in[1]
        ##1 (s_r.tmr[1].on && !s_r.tmr[1].pause && s_r.tmr[1].clksel == CK_EXT_RISE
             && s_r.tmr[1].mode == MODE_TMR && !start[1])
        |=> s_r.tmr[1].cnt != $past(s_r.tmr[1].cnt))
        else $error("rising pin edge did not advance the counter");

    a_ext_fall_count: assert property ($fell(ext_clk_in[1]) ##1 !ext_clk_in[1]
        ##1 (s_r.tmr[1].on && !s_r.tmr[1].pause && s_r.tmr[1].clksel == CK_EXT_FALL
             && s_r.tmr[1].mode == MODE_TMR && !start[1])
        |=> s_r.tmr[1].cnt != $past(s_r.tmr[1].cnt))
        else $error("falling pin edge did not advance the counter");

    a_ext_no_count: assert property (s_r.tmr[1].on && s_r.tmr[1].clksel == CK_EXT_RISE
        && s_r.tmr[1].mode == MODE_TMR && !ext_rise[1] && !start[1]
        |=> $stable(s_r.tmr[1].cnt))
        else $error("counter moved without a pin edge");

    a_match_flag_a: assert property (match_a[2] |=> s_r.status[4])
        else $error("comparator A match did not set its flag");

    a_match_p_clear: assert property (match_p[0] |=> s_r.tmr[0].cnt == 16'h0000
        && s_r.status[1])
        else $error("comparator P match did not clear the counter");

    a_status_sticky: assert property (s_r.status[0]
        && !(bus_in.wr && bus_in.addr == ADDR_INT_STAT && bus_in.wdata[0]) |=> s_r.status[0])
        else $error("status flag dropped without a clear");

    a_status_clear: assert property (bus_in.wr && bus_in.addr == ADDR_INT_STAT
        && bus_in.wdata[0] && !match_a[0] && !cap_evt[0] |=> !s_r.status[0])
        else $error("write of one did not clear the flag");

    a_start_clear: assert property (start[0] |=> s_r.tmr[0].cnt == 16'h0000)
        else $error("turning on did not clear the counter");

    a_off_hold: assert property (!s_r.tmr[2].on && !start[2] |=> $stable(s_r.tmr[2].cnt))
        else $error("counter moved while off");

    a_pause_hold: assert property (s_r.tmr[3].pause && !start[3]
        && s_r.tmr[3].mode != MODE_PWM |=> $stable(s_r.tmr[3].cnt))
        else $error("counter moved while paused");

    a_cclr_clear: assert property (match_a[2] && s_r.tmr[2].cclr |=> s_r.tmr[2].cnt == 16'h0000)
        else $error("comparator A match did not clear the counter");

    a_toggle_output: assert property (match_a[0] && s_r.tmr[0].mode == MODE_CMP
                                      && s_r.tmr[0].io == IO_TOGGLE
                                      |=> out_pin_out[0] != $past(out_pin_out[0]))
        else $error("toggle on match did not invert the output");

    a_cmp_start_level: assert property (start[0] && s_nxt.tmr[0].mode == MODE_CMP
        |=> out_pin_out[0] == $past(s_nxt.tmr[0].oc))
        else $error("turning on did not restore the initial level");

    a_cmp_hold: assert property (s_r.tmr[0].on && !start[0] && s_r.tmr[0].mode == MODE_CMP
        && !match_a[0] |=> $stable(out_pin_out[0]))
        else $error("compare output moved without a match");

    a_pwm_level: assert property (s_r.tmr[0].on && !start[0] && s_r.tmr[0].mode == MODE_PWM
                                  && s_r.tmr[0].io != IO_SINGLE
                                  |=> out_pin_out[0] == ($past(s_r.tmr[0].pol)
                                      ^ ($past(s_r.tmr[0].cnt) < $past(s_r.tmr[0].ccra))))
        else $error("PWM level wrong");

    a_capture_value: assert property (cap_evt[2]
        |=> s_r.tmr[2].ccra == $past(s_r.tmr[2].cnt) && s_r.status[4])
        else $error("capture did not store the counter");

    a_capture_hold: assert property (s_r.tmr[2].mode == MODE_CAP && !cap_evt[2]
        && !(bus_in.wr && bus_in.addr == {3'h2, REG_CCRA}) |=> $stable(s_r.tmr[2].ccra))
        else $error("capture register moved without an edge");

    a_pulse_trigger: assert property (s_r.tmr[3].on && !start[3] && s_r.tmr[3].mode == MODE_PWM
                                      && s_r.tmr[3].io == IO_SINGLE && ext_rise[3]
                                      && !s_r.tmr[3].pulse_run
                                      |=> s_r.tmr[3].pulse_run && out_pin_out[3]
                                          == !s_r.tmr[3].pol)
        else $error("trigger did not start the single pulse");

    a_pulse_end: assert property (match_a[3] && s_r.tmr[3].mode == MODE_PWM
        && s_r.tmr[3].io == IO_SINGLE
        |=> !s_r.tmr[3].pulse_run && out_pin_out[3] == $past(s_r.tmr[3].pol))
        else $error("comparator A match did not end the pulse");

    // ----------------------------------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------------------------------
    c_match_irq: cover property (match_a[0] ##1 irq_out);
    c_capture: cover property (cap_evt[2]);
    c_pulse_end: cover property (s_r.tmr[3].pulse_run ##[1:300] !s_r.tmr[3].pulse_run);
    c_ext_fall: cover property (s_r.tmr[1].clksel == CK_EXT_FALL && ext_fall[1]);
    c_pwm_wrap: cover property (match_p[0] && s_r.tmr[0].mode == MODE_PWM);
endmodule

// ### tmc_top_tb_top.sv
// Self-checking bench for the four-timer block
`timescale 1ns/1ps
module tmc_top_tb_top import tmc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    tmc_bus_t bus = '0;
    logic [3:0] ext;
    logic [3:0] cap;
    logic sub;
    logic [DW-1:0] rdata;
    logic [NUM_TMR-1:0] outp;
    logic [NUM_INV-1:0] inv;
    logic irq;
    logic [15:0] v;
    int n_mismatch = 0;
    int compares = 0;
    int hi;
    int bad;
    int rate[6] = '{64, 256, 16, 4, 32, 32};
    always #5 clk = ~clk;
    tmc_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .sub_tick_in(sub),
        .ext_clk_in(ext), .capture_in(cap), .rdata_out(rdata), .out_pin_out(outp),
        .inv_pin_out(inv), .irq_out(irq));
    tmc_pin_model pin_u (.clk_in(clk), .ext_clk_out(ext), .capture_out(cap),
        .sub_tick_out(sub));
    // ----------------------------------------------------------------
    // Bus access and checking
    // ----------------------------------------------------------------
    task automatic conclude();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi_lim,
        input string what);
        logic ok;
        ok = (got >= lo) && (got <= hi_lim);
        compares++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %0d", $time, what, got);
        end
    endtask
    // The #1 lets the write land before anyone looks at its effect
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [AW-1:0] a);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [AW-1:0] ra(input int t, input logic [2:0] r);
        return {t[2:0], r};
    endfunction
    function automatic logic [15:0] c0(input logic [2:0] ck, input logic on, input logic cs);
        return {8'h00, 1'b0, ck, on, 2'h0, cs};
    endfunction
    function automatic logic [15:0] c1(input tmc_mode_t m, input logic [1:0] io,
        input logic oc);
        return {8'h00, m, io, oc, 3'h0};
    endfunction
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        chk({14'h0, inv}, 16'h0003, "inv in reset");
        chk({12'h0, outp}, 16'h0000, "out in reset");
        rst_n <= 1'b1;
        wr(ra(0, REG_CNT), 16'h1234);
        rd(ra(0, REG_CNT));
        chk(v, 16'h0000, "cnt read only");
        wr(ra(1, REG_CCRA), 16'hA5C3);
        wr(ra(1, REG_CCRP), 16'hFF5A);
        wr(6'h05, 16'hFFFF);
        rd(ra(1, REG_CCRA));
        chk(v, 16'hA5C3, "ccra");
        rd(ra(1, REG_CCRP));
        chk(v, 16'h005A, "ccrp");
        rd(6'h05);
        chk(v, 16'h0000, "unmapped");
        for (int t = 0; t < NUM_TMR; t++) begin
            for (int io = 1; io < 4; io++) begin
                wr(ra(t, REG_CCRA), 16'h0003);
                wr(ra(t, REG_CCRP), 16'h0000);
                wr(ra(t, REG_CTRL1), c1(MODE_CMP, 2'(io), io == 1));
                wr(ADDR_INT_STAT, 16'h00FF);
                wr(ra(t, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
                repeat (20) @(posedge clk);
                chk(16'(outp[t]), 16'(io != 1), "match output");
                if (t < NUM_INV) chk(16'(inv[t]), 16'(io == 1), "inverted");
                rd(ADDR_INT_STAT);
                chk(v, 16'h0001 << (2 * t), "status");
                chk(16'(irq), 16'h0000, "masked irq");
                wr(ADDR_INT_MASK, 16'h0001 << (2 * t));
                chk(16'(irq), 16'h0001, "unmasked irq");
                wr(ADDR_INT_STAT, 16'h0001 << (2 * t));
                chk(16'(irq), 16'h0000, "cleared irq");
                wr(ADDR_INT_MASK, 16'h0000);
                wr(ra(t, REG_CTRL0), 16'h0000);
            end
        end
        wr(ra(2, REG_CTRL1), c1(MODE_TMR, 2'h0, 1'b0) | 16'h0001);
        wr(ra(2, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
        repeat (20) @(posedge clk);
        rd(ra(2, REG_CNT));
        chk_rng(v, 0, 3, "clear on match");
        wr(ra(2, REG_CTRL0), 16'h0000);
        wr(ra(1, REG_CTRL1), c1(MODE_TMR, 2'h0, 1'b0));
        for (int e = 0; e < 2; e++) begin
            wr(ra(1, REG_CTRL0), c0(e ? CK_EXT_FALL : CK_EXT_RISE, 1'b1, 1'b0));
            pin_u.ext_pulses(1, 5);
            repeat (4) @(posedge clk);
            rd(ra(1, REG_CNT));
            chk(v, 16'h0005, "pin edges");
            wr(ra(1, REG_CTRL0), 16'h0000);
        end
        wr(ra(3, REG_CTRL1), c1(MODE_TMR, 2'h0, 1'b0));
        for (int k = 0; k < 6; k++) begin
            wr(ra(3, REG_CTRL0), c0(3'(k), 1'b1, 1'b0));
            repeat (254) @(posedge clk);
            wr(ra(3, REG_CTRL0), 16'h0000);
            rd(ra(3, REG_CNT));
            chk_rng(v, rate[k] - 2, rate[k] + 2, "clock rate");
        end
        wr(ra(3, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
        wr(ra(3, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0) | 16'h0080);
        repeat (10) @(posedge clk);
        rd(ra(3, REG_CNT));
        chk(v, 16'h0002, "pause holds");
        wr(ra(3, REG_CTRL0), 16'h0000);
        for (int io = 0; io < 3; io++) begin
            wr(ra(2, REG_CCRA), 16'hF000);
            wr(ra(2, REG_CTRL1), c1(MODE_CAP, 2'(io), 1'b0));
            wr(ra(2, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
            wr(ADDR_INT_STAT, 16'h00FF);
            for (int lvl = 1; lvl >= 0; lvl--) begin
                pin_u.set_cap(2, lvl[0]);
                repeat (5) @(posedge clk);
                rd(ADDR_INT_STAT);
                chk(16'(v[4]), 16'(lvl ? io != 1 : io != 0), "capture");
                wr(ADDR_INT_STAT, 16'h00FF);
            end
            wr(ra(2, REG_CTRL0), 16'h0000);
        end
        wr(ra(2, REG_CCRA), 16'hF000);
        wr(ra(2, REG_CTRL1), c1(MODE_CAP, CAP_RISE, 1'b0));
        wr(ra(2, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b1));
        pin_u.ext_pulses(2, 1);
        rd(ADDR_INT_STAT);
        chk(16'(v[4]), 16'h0001, "capture on clock pin");
        wr(ra(3, REG_CTRL1), c1(MODE_CMP, 2'h0, 1'b0));
        wr(ra(3, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
        wr(ra(3, REG_CTRL0), 16'h0000);
        wr(ra(3, REG_CCRA), 16'h000A);
        wr(ra(3, REG_CTRL1), c1(MODE_PWM, IO_SINGLE, 1'b0));
        wr(ra(3, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
        repeat (5) @(posedge clk);
        chk(16'(outp[3]), 16'h0000, "pulse idle");
        pin_u.ext_pulses(3, 1);
        #1 chk(16'(outp[3]), 16'h0001, "pulse active");
        repeat (20) @(posedge clk);
        chk(16'(outp[3]), 16'h0000, "pulse end");
        wr(ra(0, REG_CCRA), 16'h0040);
        wr(ra(0, REG_CCRP), 16'h0001);
        wr(ra(0, REG_CTRL1), c1(MODE_PWM, 2'h0, 1'b0));
        wr(ra(0, REG_CTRL0), c0(CK_SYS, 1'b1, 1'b0));
        hi = 0;
        bad = 0;
        repeat (514) begin
            @(posedge clk);
            #1 hi += int'(outp[0]);
            bad += int'(inv[0] !== ~outp[0]);
        end
        chk_rng(16'(hi), 124, 132, "pwm duty");
        chk(16'(bad), 16'h0000, "pwm inverted");
        conclude();
    end
endmodule
